/* spfe_regs.vh */
/*
 * Constants for the serial flash front end: byte framing and lane layout.
 * Assumes inclusion by the front end modules only; definitions only.
 */
`ifndef SPFE_REGS_VH
`define SPFE_REGS_VH

// Bits per byte on the wire
`define SPFE_BYTE_W 8
// Bit counter width inside one byte
`define SPFE_CNT_W 3
// Last bit index of a byte in single mode
`define SPFE_CNT_LAST_SINGLE 3'h7
// Last pair index of a byte in dual mode
`define SPFE_CNT_LAST_DUAL 3'h3
// Synchroniser depth in flip-flops
`define SPFE_SYNC_STAGES 2

`endif

/* spfe_sync.v */
/*
 * Two-flop synchroniser with edge detection on the synchronised level.
 * Assumes an asynchronous pin input and the single core clock.
 */
`timescale 1ns/1ns
`default_nettype none

module spfe_sync
(
    // Clock and reset
    input wire i_core_clk,
    input wire i_rst_b,
    // Pin side
    input wire i_pin,
    input wire i_rst_val,
    // Core side
    output reg o_level,
    output reg o_rise,
    output reg o_fall
);

    reg meta;
    reg stable;

    // First flop feeds only the second; edges are taken after it
    // Reset to the pin's idle level so release gives no false edge
    always @(posedge i_core_clk)
    begin
        if (!i_rst_b)
        begin
            meta <= i_rst_val;
            stable <= i_rst_val;
            o_level <= i_rst_val;
            o_rise <= 1'b0;
            o_fall <= 1'b0;
        end
        else
        begin
            meta <= i_pin;
            stable <= meta;
            o_level <= stable;
            o_rise <= stable & ~o_level;
            o_fall <= ~stable & o_level;
        end
    end

endmodule

`default_nettype wire

/* spfe_front_end.v */
/*
 * Serial flash SPI front end: frames operations on chip select, shifts
 * command, address and data in on serial clock rises, shifts read data out
 * on falls, single or dual lane.
 * Assumes the serial clock is far slower than the core clock (several core
 * cycles per half period) and a command decoder on the user side.
 */
// Function
// (R1) Works with the serial clock idling low or high between operations.
// (R2) Only a falling chip select starts a new command sequence.
// (R3) A rising chip select ends the current command.
// (R4) Deselected: standby, not deep power-down, serial output undriven.
// (R5) Deselected: the serial input is ignored, no bits captured.
// (R6) Self-timed program or erase finishes before standby is entered.
// (R7) Opcode, address and write data sampled on serial clock rises.
// (R8) Output data bit changes on serial clock falls.
// (R9) Dual read drives both lanes, two bits per falling edge.
// (R10) Most significant bit first; lane 1 carries the higher bit.
// (R11) Chip select rise drops partial bytes and returns shifters to idle.
`timescale 1ns/1ns
`default_nettype none
`include "spfe_regs.vh"

module spfe_front_end
(
    // Clock and reset
    input wire i_core_clk,
    input wire i_rst_b,
    // Serial pins (asynchronous)
    input wire i_cs_b,
    input wire i_sck,
    input wire i_dual_io_lane0,
    input wire i_dual_io_lane1,
    output reg o_dual_io_lane0,
    output reg o_dual_io_lane0_oe,
    output reg o_dual_io_lane1,
    output reg o_dual_io_lane1_oe,
    // Framing towards the command decoder
    output reg o_cmd_start,
    output reg o_cmd_end,
    output reg o_selected,
    // Received bytes
    output reg [`SPFE_BYTE_W-1:0] o_rx_byte,
    output reg o_rx_valid,
    // Transmit bytes
    input wire i_tx_en,
    input wire i_tx_dual,
    input wire [`SPFE_BYTE_W-1:0] i_tx_byte,
    output reg o_tx_take,
    // Self-timed operation status and power state
    input wire i_busy,
    output reg o_standby
);

    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_SEL = 2'b10;

    reg [1:0] state;
    reg [`SPFE_BYTE_W-1:0] rx_sr;
    reg [`SPFE_CNT_W-1:0] rx_cnt;
    reg [`SPFE_BYTE_W-1:0] tx_sr;
    reg [`SPFE_CNT_W-1:0] tx_cnt;
    reg tx_dual;

    wire cs_level;
    wire cs_rise;
    wire cs_fall;
    wire sck_rise;
    wire sck_fall;
    wire si_level;
    wire lane1_level;

    // Pins pass three flops; all share the same latency so data aligns with edges
    spfe_sync u_cs
    (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_pin(i_cs_b),
        .i_rst_val(1'b1),
        .o_level(cs_level),
        .o_rise(cs_rise),
        .o_fall(cs_fall)
    );

    spfe_sync u_sck
    (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_pin(i_sck),
        .i_rst_val(1'b0),
        .o_level(),
        .o_rise(sck_rise),
        .o_fall(sck_fall)
    );

    spfe_sync u_si
    (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_pin(i_dual_io_lane0),
        .i_rst_val(1'b0),
        .o_level(si_level),
        .o_rise(),
        .o_fall()
    );

    // Lane 1 is only an input in dual-input writes, unused here
    spfe_sync u_lane1
    (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_pin(i_dual_io_lane1),
        .i_rst_val(1'b0),
        .o_level(lane1_level),
        .o_rise(),
        .o_fall()
    );

    wire unused_lane1;
    assign unused_lane1 = lane1_level ^ cs_level;

    // Framing state; edge of select only, never its level, opens a frame
    always @(posedge i_core_clk)
    begin
        if (!i_rst_b)
        begin
            state <= ST_IDLE;
            o_cmd_start <= 1'b0;
            o_cmd_end <= 1'b0;
        end
        else
        begin
            o_cmd_start <= 1'b0;
            o_cmd_end <= 1'b0;
            case (state)
                ST_IDLE:
                begin
                    if (cs_fall) // R2
                    begin
                        state <= ST_SEL;
                        o_cmd_start <= 1'b1;
                    end
                end
                ST_SEL:
                begin
                    if (cs_rise) // R3
                    begin
                        state <= ST_IDLE;
                        o_cmd_end <= 1'b1;
                    end
                end
                default:
                begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Receive shifter; rises only count while selected and not driving lane 0
    // Clock idle level is irrelevant: only edges inside the frame act
    always @(posedge i_core_clk)
    begin
        if (!i_rst_b)
        begin
            rx_sr <= {`SPFE_BYTE_W{1'b0}};
            rx_cnt <= {`SPFE_CNT_W{1'b0}};
            o_rx_byte <= {`SPFE_BYTE_W{1'b0}};
            o_rx_valid <= 1'b0;
        end
        else
        begin
            o_rx_valid <= 1'b0;
            if (state != ST_SEL || cs_rise) // R5 R11
            begin
                rx_sr <= {`SPFE_BYTE_W{1'b0}};
                rx_cnt <= {`SPFE_CNT_W{1'b0}};
            end
            else if (sck_rise && !o_dual_io_lane0_oe) // R7 R1
            begin
                rx_sr <= {rx_sr[`SPFE_BYTE_W-2:0], si_level}; // R10
                rx_cnt <= rx_cnt + 3'h1;
                if (rx_cnt == `SPFE_CNT_LAST_SINGLE)
                begin
                    o_rx_byte <= {rx_sr[`SPFE_BYTE_W-2:0], si_level};
                    o_rx_valid <= 1'b1;
                end
            end
        end
    end

    // Transmit shifter; a byte is fetched on the fall that needs its first bit
    always @(posedge i_core_clk)
    begin
        if (!i_rst_b)
        begin
            tx_sr <= {`SPFE_BYTE_W{1'b0}};
            tx_cnt <= {`SPFE_CNT_W{1'b0}};
            tx_dual <= 1'b0;
            o_tx_take <= 1'b0;
            o_dual_io_lane0 <= 1'b0;
            o_dual_io_lane1 <= 1'b0;
        end
        else
        begin
            o_tx_take <= 1'b0;
            if (state != ST_SEL || cs_rise || !i_tx_en) // R11
            begin
                tx_cnt <= {`SPFE_CNT_W{1'b0}};
                tx_dual <= 1'b0;
            end
            else if (sck_fall) // R8
            begin
                if (tx_cnt == 3'h0)
                begin
                    o_tx_take <= 1'b1;
                    tx_dual <= i_tx_dual;
                    if (i_tx_dual) // R9 R10
                    begin
                        o_dual_io_lane1 <= i_tx_byte[7];
                        o_dual_io_lane0 <= i_tx_byte[6];
                        tx_sr <= {i_tx_byte[5:0], 2'b00};
                    end
                    else
                    begin
                        o_dual_io_lane1 <= i_tx_byte[7];
                        tx_sr <= {i_tx_byte[6:0], 1'b0};
                    end
                    tx_cnt <= 3'h1;
                end
                else if (tx_dual) // R9
                begin
                    o_dual_io_lane1 <= tx_sr[7];
                    o_dual_io_lane0 <= tx_sr[6];
                    tx_sr <= {tx_sr[5:0], 2'b00};
                    if (tx_cnt == `SPFE_CNT_LAST_DUAL)
                        tx_cnt <= 3'h0;
                    else
                        tx_cnt <= tx_cnt + 3'h1;
                end
                else
                begin
                    o_dual_io_lane1 <= tx_sr[7]; // R10
                    tx_sr <= {tx_sr[6:0], 1'b0};
                    tx_cnt <= tx_cnt + 3'h1; // Wraps to 0 after bit 7
                end
            end
        end
    end

    // Enables and power state; standby waits for self-timed work to end
    always @(posedge i_core_clk)
    begin
        if (!i_rst_b)
        begin
            o_dual_io_lane1_oe <= 1'b0;
            o_dual_io_lane0_oe <= 1'b0;
            o_selected <= 1'b0;
            o_standby <= 1'b1;
        end
        else
        begin
            o_selected <= (state == ST_SEL) && !cs_rise;
            o_dual_io_lane1_oe <= (state == ST_SEL) && !cs_rise && i_tx_en; // R4
            o_dual_io_lane0_oe <= (state == ST_SEL) && !cs_rise && i_tx_en
                                  && i_tx_dual; // R9
            o_standby <= (state == ST_IDLE) && !i_busy; // R4 R6
        end
    end

endmodule

`default_nettype wire

/* spfe_front_end_assertions.sv */
/* Checker for the serial flash front end ports.
   Assumes a bind onto spfe_front_end and one core clock. */
`timescale 1ns/1ns
`default_nettype none
module spfe_checker (
    input wire logic i_core_clk, i_rst_b, i_cs_b, i_sck, i_busy,
    input wire logic o_cmd_start, o_cmd_end, o_rx_valid, o_standby,
    input wire logic o_dual_io_lane0_oe, o_dual_io_lane1_oe, o_dual_io_lane1
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);
    // Sync pipe gives three to five cycles of framing latency
    a_start_on_fall: assert property ($fell(i_cs_b) |-> ##[3:5] o_cmd_start)
        else $error("select fall gave no start");
    a_start_cause: assert property (o_cmd_start |-> !$past(i_cs_b, 3))
        else $error("start without select fall");
    a_end_on_rise: assert property ($rose(i_cs_b) |-> ##[3:5] o_cmd_end)
        else $error("select rise gave no end");
    a_desel_hiz: assert property (i_cs_b [*6] |-> !o_dual_io_lane1_oe && !o_dual_io_lane0_oe)
        else $error("lane driven while deselected");
    a_desel_no_rx: assert property (i_cs_b [*6] |-> !o_rx_valid)
        else $error("byte taken while deselected");
    a_standby_idle: assert property ((i_cs_b && !i_busy) [*8] |=> o_standby)
        else $error("no standby when idle");
    a_busy_holds: assert property (i_busy |=> !o_standby)
        else $error("standby while busy");
    a_dual_pair: assert property (o_dual_io_lane0_oe |-> o_dual_io_lane1_oe)
        else $error("lane 0 driven alone");
    // Output may move only a few cycles after a clock fall
    a_out_on_fall: assert property (o_dual_io_lane1_oe && $past(o_dual_io_lane1_oe)
        && $changed(o_dual_io_lane1) |-> !$past(i_sck, 2))
        else $error("output moved outside low phase");
endmodule
`default_nettype wire

/* spfe_host_model.sv */
/* Host model: select, serial clock and lane pins in mode 0 or 3.
   Assumes the bench resolves the two-way lanes and paces on core clock. */
`timescale 1ns/1ns
`default_nettype none
module spfe_host_model (
    input wire logic i_core_clk,
    input wire logic i_lane0,
    input wire logic i_lane1,
    output logic o_cs_b,
    output logic o_sck,
    output logic o_si
);
    logic mode3;
    // Idle pins: deselected, clock low
    initial
    begin
        o_cs_b = 1'b1;
        o_sck = 1'b0;
        o_si = 1'b0;
        mode3 = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge i_core_clk);
    endtask
    // Idle level chosen before the select falls
    task automatic sel(input logic m3);
        mode3 = m3;
        @(posedge i_core_clk);
        o_sck <= m3;
        wt(4);
        o_cs_b <= 1'b0;
        wt(8);
    endtask
    task automatic desel;
        @(posedge i_core_clk);
        o_sck <= mode3;
        wt(4);
        o_cs_b <= 1'b1;
        wt(8);
    endtask
    // Fall, drive, rise; sample late in high phase so output has settled
    task automatic xfer(input logic [7:0] tx, input logic dual, input int nb,
        output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 0; i < nb; i++)
        begin
            @(posedge i_core_clk);
            o_sck <= 1'b0;
            o_si <= tx[7 - i];
            wt(4);
            o_sck <= 1'b1;
            // Four core cycles high, four low: 160 ns link clock
            wt(3);
            rx = dual ? {rx[5:0], i_lane1, i_lane0} : {rx[6:0], i_lane1};
        end
    endtask
endmodule
`default_nettype wire

/* test_serial_flash_spi_front_end.sv */
/* Self-checking bench for the serial flash front end.
   Assumes the host model and checker files are compiled first. */
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_count++; \
    $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module test_serial_flash_spi_front_end;
    logic i_core_clk, i_rst_b, i_tx_en, i_tx_dual, i_busy, last1, clr;
    logic [7:0] i_tx_byte, rx, rx_last;
    wire cs_b, sck, si, o0, o0_oe, o1, o1_oe, st, en, sl, rxv, tk, stby, l0, l1;
    wire [7:0] rxb;
    int err_count, check_count, rx_n, st_n, en_n, tk_n, oe0_n;
    // Released lane 1 shows the inverse of its last value
    assign l0 = o0_oe ? o0 : si;
    assign l1 = o1_oe ? o1 : ~last1;
    initial
    begin
        i_core_clk = 1'b0;
        forever #10 i_core_clk = ~i_core_clk;
    end
    spfe_front_end dut_u (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_cs_b(cs_b),
        .i_sck(sck), .i_dual_io_lane0(l0), .i_dual_io_lane1(l1), .o_dual_io_lane0(o0),
        .o_dual_io_lane0_oe(o0_oe), .o_dual_io_lane1(o1), .o_dual_io_lane1_oe(o1_oe),
        .o_cmd_start(st), .o_cmd_end(en), .o_selected(sl), .o_rx_byte(rxb),
        .o_rx_valid(rxv), .i_tx_en(i_tx_en), .i_tx_dual(i_tx_dual),
        .i_tx_byte(i_tx_byte), .o_tx_take(tk), .i_busy(i_busy), .o_standby(stby));
    spfe_host_model host_u (.i_core_clk(i_core_clk), .i_lane0(l0), .i_lane1(l1),
        .o_cs_b(cs_b), .o_sck(sck), .o_si(si));
    // Pulse counters, cleared at the start of each scenario except the busy one
    always @(posedge i_core_clk)
    begin
        last1 <= o1_oe ? o1 : last1;
        rx_n <= clr ? 0 : rx_n + rxv;
        st_n <= clr ? 0 : st_n + st;
        en_n <= clr ? 0 : en_n + en;
        tk_n <= clr ? 0 : tk_n + tk;
        oe0_n <= clr ? 0 : oe0_n + o0_oe;
        rx_last <= rxv ? rxb : rx_last;
    end
    task automatic zero;
        @(posedge i_core_clk);
        clr <= 1'b1;
        @(posedge i_core_clk);
        clr <= 1'b0;
    endtask
    task automatic t_rx(input logic m3);
        zero();
        host_u.sel(m3);
        host_u.xfer(8'ha5, 1'b0, 8, rx);
        host_u.wt(3);
        `CHK(rx_last, 8'ha5)
        `CHK(sl, 1'b1)
        host_u.xfer(8'h3c, 1'b0, 8, rx);
        host_u.wt(3);
        `CHK(rx_last, 8'h3c)
        host_u.desel();
        `CHK({rx_n, st_n, en_n}, {32'd2, 32'd1, 32'd1})
        `CHK(sl, 1'b0)
        $display("rx test done");
    endtask
    task automatic t_tx(input logic dual, input logic [7:0] b);
        zero();
        host_u.sel(dual);
        host_u.xfer(8'h0b, 1'b0, 8, rx);
        host_u.wt(2);
        i_tx_byte <= b;
        i_tx_dual <= dual;
        i_tx_en <= 1'b1;
        host_u.xfer(8'h55, dual, dual ? 4 : 8, rx);
        i_tx_en <= 1'b0;
        `CHK(rx, b)
        host_u.desel();
        `CHK(tk_n, 1)
        `CHK(oe0_n > 0, dual)
        $display("tx test done");
    endtask
    task automatic t_part;
        zero();
        host_u.sel(1'b1);
        host_u.xfer(8'hff, 1'b0, 3, rx);
        host_u.desel();
        host_u.sel(1'b1);
        host_u.xfer(8'h81, 1'b0, 8, rx);
        host_u.wt(3);
        `CHK(rx_n, 1)
        `CHK(rx_last, 8'h81)
        host_u.desel();
        host_u.xfer(8'hf0, 1'b0, 8, rx);
        host_u.wt(4);
        `CHK({rx_n, st_n, en_n}, {32'd1, 32'd2, 32'd2})
        `CHK(stby, 1'b1)
        $display("partial and deselect test done");
    endtask
    task automatic t_busy;
        host_u.sel(1'b0);
        i_busy <= 1'b1;
        host_u.desel();
        `CHK(stby, 1'b0)
        i_busy <= 1'b0;
        host_u.wt(3);
        `CHK(stby, 1'b1)
        $display("busy test done");
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Hang guard
    initial
    begin
        repeat (20000) @(posedge i_core_clk);
        err_count++;
        finish_test();
    end
    // Reset, then scenarios
    initial
    begin
        {i_rst_b, i_tx_en, i_tx_dual, i_busy, last1, clr} = 6'h00;
        i_tx_byte = 8'h00;
        repeat (20) @(posedge i_core_clk);
        i_rst_b <= 1'b1;
        host_u.wt(6);
        `CHK({stby, o1_oe, o0_oe}, 3'h4)
        t_rx(1'b0);
        t_rx(1'b1);
        t_tx(1'b0, 8'hc6);
        t_tx(1'b1, 8'h9d);
        t_part();
        t_busy();
        finish_test();
    end
endmodule
bind spfe_front_end spfe_checker chk_u (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
    .i_cs_b(i_cs_b), .i_sck(i_sck), .i_busy(i_busy), .o_cmd_start(o_cmd_start),
    .o_cmd_end(o_cmd_end), .o_rx_valid(o_rx_valid), .o_standby(o_standby),
    .o_dual_io_lane0_oe(o_dual_io_lane0_oe), .o_dual_io_lane1_oe(o_dual_io_lane1_oe),
    .o_dual_io_lane1(o_dual_io_lane1));
`default_nettype wire
